// ==== logic/osc_ctrl_regs.sv ====
// Oscillator control and status register block with APB slave and event interrupt
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
module osc_ctrl_regs
   import osc_ctrl_pkg::*;
#(
   parameter int VARIANT = VAR_PLAIN // Register variant, 1 or 2
) (
   input wire logic pclk, // Bus and block clock, 50 MHz
   input wire logic presetn, // Power-on reset, async, low active
   input wire logic clk_en, // Freezes all state while low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [1:0] powerup_source_config, // Source chosen by nonvolatile config
   input wire logic brown_out_reset, // Brown-out reset, synchronous level
   input wire logic switch_done, // Switch sequencer finished, pulse
   input wire logic failsafe_fail, // Fail-safe monitor saw a failure, pulse
   input wire logic pll_locked, // PLL lock detector level
   input wire logic pll_in_use, // PLL drives the system clock
   output logic [1:0] current_clock_source, // Source now clocking the system
   output logic [1:0] requested_clock_source, // Target of the switch
   output logic clock_switch_request, // Switch pending
   output logic low_power_crystal_enable, // Turns on the 32 kHz crystal
   output logic [3:0] fast_rc_trim, // Fast RC frequency offset
   output logic sysclk_tick, // One pulse per divided system clock
   output logic irq // Level interrupt
);

   // Refuse variants the decode cannot serve
   if (VARIANT != VAR_PLAIN && VARIANT != VAR_TRIM) begin : g_bad_variant
      $error("osc_ctrl_regs: VARIANT must be 1 or 2");
   end

   // Divide select to counter mask, 1 << (2 * sel) minus one
   function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [1:0] sel);
      case (sel)
         2'b00: div_mask = 6'h00;
         2'b01: div_mask = 6'h03;
         2'b10: div_mask = 6'h0f;
         default: div_mask = 6'h3f;
      endcase
   endfunction

   // Address decode, used only by the error answer; the read path decodes paddr in its own case
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFF_CTRL) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
   endfunction

   src_t cur_q; // Current source
   src_t new_q; // Requested source
   logic swreq_q; // Switch request
   logic lpxen_q; // Crystal enable
   logic fail_q; // Clock failure flag
   logic lock_q; // Raw lock flag
   logic [1:0] div_q; // Divide select
   logic [3:0] trim_q; // Fast RC trim
   logic load_q; // Reload sources from config at next edge
   logic [DIV_CNT_W-1:0] div_cnt_q; // Postscaler counter
   logic tick_q; // Registered divided tick
   logic [IRQ_W-1:0] stat_q; // Sticky events
   logic [IRQ_W-1:0] mask_q; // Event mask
   logic [IRQ_W-1:0] evt; // Event pulses this cycle
   logic [31:0] prdata_q; // Read data, captured in setup
   logic [31:0] ctrl_rd; // Assembled control word
   logic xfer; // Transfer completes at this edge
   logic ctrl_wr; // Write to the control word
   logic [1:0] lane_wr; // Write hitting each control byte
   logic [1:0] ul_open; // Unlock grant window per byte
   logic [1:0] ul_key; // First key seen per byte
   logic [1:0] grant; // Write applied per byte
   logic sw_start; // A real switch begins
   logic lock_rd; // Lock as software sees it

   // APB handshake: no wait states, ready only while enabled
   assign pready = psel & penable & clk_en;
   assign xfer = pready;
   assign pslverr = pready & ~is_mapped(paddr);
   assign prdata = prdata_q;
   assign ctrl_wr = xfer & pwrite & (paddr == OFF_CTRL);
   assign lane_wr = {ctrl_wr & pstrb[1], ctrl_wr & pstrb[0]};

   // One unlock sequencer per control byte; any completed transfer advances it,
   // so a read or a write elsewhere between keys or before the grant aborts
   for (genvar g = 0; g < 2; g++) begin : g_unlock
      unlock_t st_q; // Sequencer state
      logic [7:0] wbyte; // Byte of write data for this lane
      assign wbyte = pwdata[8*g +: 8];
      assign ul_open[g] = (st_q == UL_OPEN);
      assign ul_key[g] = (st_q == UL_KEY);
      assign grant[g] = ul_open[g] & lane_wr[g];

      // Key tracking
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            st_q <= UL_IDLE;
         end else if (clk_en && brown_out_reset) begin
            st_q <= UL_IDLE;
         end else if (xfer) begin
            case (st_q)
               UL_IDLE: begin
                  // First key opens the sequence
                  if (lane_wr[g] && wbyte == KEY_FIRST[g]) begin
                     st_q <= UL_KEY;
                  end
               end
               UL_KEY: begin
                  // Second key grants, a repeated first key restarts
                  if (lane_wr[g] && wbyte == KEY_SECOND[g]) begin
                     st_q <= UL_OPEN;
                  end else if (lane_wr[g] && wbyte == KEY_FIRST[g]) begin
                     st_q <= UL_KEY;
                  end else begin
                     st_q <= UL_IDLE;
                  end
               end
               UL_OPEN: begin
                  // Window lasts exactly one transfer
                  st_q <= UL_IDLE;
               end
               default: begin
                  st_q <= UL_IDLE;
               end
            endcase
         end
      end
   end

   // A switch starts only when the target differs from the running source
   assign sw_start = grant[0] & pwdata[BIT_SWREQ] & ~swreq_q & (new_q != cur_q);

   // Reload request: set by either reset, taken at the next enabled edge.
   // The config pins are never sampled under the async reset itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_q <= 1'b1;
      end else if (clk_en) begin
         load_q <= brown_out_reset;
      end
   end

   // Current source: config at reset, target on switch, fast RC on failure
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= SRC_FAST_RC;
      end else if (clk_en) begin
         if (load_q) begin
            cur_q <= src_t'(powerup_source_config);
         end else if (failsafe_fail) begin
            cur_q <= SRC_FAST_RC;
         end else if (swreq_q && switch_done) begin
            cur_q <= new_q;
         end
      end
   end

   // Requested source: config at reset, high byte write after unlock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         new_q <= SRC_FAST_RC;
      end else if (clk_en) begin
         if (load_q) begin
            new_q <= src_t'(powerup_source_config);
         end else if (grant[1]) begin
            new_q <= src_t'(pwdata[POS_NEW +: 2]);
         end
      end
   end

   // Switch request: redundant requests never set, done or failure clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swreq_q <= 1'b0;
      end else if (clk_en) begin
         if (load_q || brown_out_reset || failsafe_fail) begin
            swreq_q <= 1'b0;
         end else if (swreq_q && switch_done) begin
            swreq_q <= 1'b0;
         end else if (grant[0]) begin
            swreq_q <= pwdata[BIT_SWREQ] & (new_q != cur_q);
         end
      end
   end

   // Divide select and crystal enable, low byte after unlock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= DIV_RESET;
         lpxen_q <= 1'b0;
      end else if (clk_en) begin
         if (brown_out_reset) begin
            div_q <= DIV_RESET;
            lpxen_q <= 1'b0;
         end else if (grant[0]) begin
            div_q <= pwdata[POS_DIV +: 2];
            lpxen_q <= pwdata[BIT_LPXEN];
         end
      end
   end

   // Failure flag: the monitor's set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q <= 1'b0;
      end else if (clk_en) begin
         if (failsafe_fail) begin
            fail_q <= 1'b1;
         end else if (brown_out_reset || sw_start) begin
            fail_q <= 1'b0;
         end else if (grant[0]) begin
            fail_q <= pwdata[BIT_FAIL];
         end
      end
   end

   // Lock flag follows the detector but drops when a switch starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= 1'b0;
      end else if (clk_en) begin
         if (brown_out_reset || sw_start) begin
            lock_q <= 1'b0;
         end else begin
            lock_q <= pll_locked;
         end
      end
   end

   // Software sees no lock while the PLL is not the system clock
   assign lock_rd = lock_q & pll_in_use;

   // Trim field lives only in the second variant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_q <= TRIM_RESET;
      end else if (clk_en) begin
         if (brown_out_reset) begin
            trim_q <= TRIM_RESET;
         end else if (grant[1] && VARIANT == VAR_TRIM) begin
            trim_q <= {pwdata[POS_TRIM_HI +: 2], pwdata[POS_TRIM_LO +: 2]};
         end
      end
   end

   // Control word read view; unimplemented bits stay zero
   always_comb begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[BIT_SWREQ] = swreq_q;
      ctrl_rd[BIT_LPXEN] = lpxen_q;
      ctrl_rd[BIT_FAIL] = fail_q;
      ctrl_rd[BIT_LOCK] = lock_rd;
      ctrl_rd[POS_DIV +: 2] = div_q;
      ctrl_rd[POS_NEW +: 2] = new_q;
      ctrl_rd[POS_CUR +: 2] = cur_q;
      if (VARIANT == VAR_TRIM) begin
         ctrl_rd[POS_TRIM_HI +: 2] = trim_q[3:2];
         ctrl_rd[POS_TRIM_LO +: 2] = trim_q[1:0];
      end
   end

   // Postscaler: free running count, tick when the masked bits are all ones.
   // A change of ratio can give one short period; no glitch, just early.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         div_cnt_q <= div_cnt_q + 1'b1;
         tick_q <= (div_cnt_q & div_mask(div_q)) == div_mask(div_q);
      end
   end

   // Events feeding the interrupt status
   always_comb begin
      evt = '0;
      evt[EVT_FAIL] = failsafe_fail;
      evt[EVT_SWITCH] = swreq_q & switch_done & ~failsafe_fail & ~load_q;
      evt[EVT_LOCKLOST] = lock_q & ~pll_locked & ~brown_out_reset;
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= IRQ_RESET;
      end else if (clk_en) begin
         if (xfer && pwrite && paddr == OFF_IRQ_STAT && pstrb[0]) begin
            stat_q <= (stat_q & ~pwdata[IRQ_W-1:0]) | evt;
         end else begin
            stat_q <= stat_q | evt;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= IRQ_RESET;
      end else if (clk_en && xfer && pwrite && paddr == OFF_IRQ_MASK && pstrb[0]) begin
         mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // Read data captured in the setup cycle, zero for unmapped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (clk_en && psel && !penable) begin
         case (paddr)
            OFF_CTRL: prdata_q <= ctrl_rd;
            OFF_IRQ_STAT: prdata_q <= {{(32-IRQ_W){1'b0}}, stat_q};
            OFF_IRQ_MASK: prdata_q <= {{(32-IRQ_W){1'b0}}, mask_q};
            default: prdata_q <= '0;
         endcase
      end
   end

   assign current_clock_source = cur_q;
   assign requested_clock_source = new_q;
   assign clock_switch_request = swreq_q;
   assign low_power_crystal_enable = lpxen_q;
   assign fast_rc_trim = trim_q;
   assign sysclk_tick = tick_q;
   assign irq = |(stat_q & mask_q);

   // Lock never reaches the read data while another source clocks the system
   a_lock_gated: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && psel && !penable && paddr == OFF_CTRL && !pll_in_use |=> !prdata[BIT_LOCK])
      else $error("lock visible without PLL");
   // Write without unlock leaves low fields alone
   a_locked_low: assert property (@(posedge pclk) disable iff (!presetn)
      lane_wr[0] && !ul_open[0] && !brown_out_reset |=>
      $stable(div_q) && $stable(lpxen_q)) else $error("locked low byte changed");
   // Finished switch moves the target into the current source and drops the request
   a_switch_done: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && swreq_q && switch_done && !failsafe_fail && !load_q |=>
      cur_q == $past(new_q) && !swreq_q) else $error("switch not completed");
   // Monitor failure on an enabled edge always sets the flag
   a_fail_set: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && failsafe_fail |=> fail_q) else $error("failure flag not set");
   // Low grant only after both keys in order
   a_open_low: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ul_open[0]) |-> $past(ul_key[0]) && $past(pwdata[7:0]) == KEY_SECOND[0])
      else $error("low byte opened without keys");
   // High grant only after both keys in order
   a_open_high: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ul_open[1]) |-> $past(ul_key[1]) && $past(pwdata[15:8]) == KEY_SECOND[1])
      else $error("high byte opened without keys");
   // A foreign transfer between keys ends the sequence
   a_key_abort: assert property (@(posedge pclk) disable iff (!presetn)
      ul_key[0] && xfer && !lane_wr[0] |=> !ul_key[0] && !ul_open[0])
      else $error("unlock survived other transfer");
   // Switch start clears the lock flag for at least that cycle
   a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
      sw_start |=> !lock_q && !fail_q || $past(failsafe_fail))
      else $error("flags not cleared on switch start");
   // Redundant switch request is never held
   a_redundant: assert property (@(posedge pclk) disable iff (!presetn)
      grant[0] && !load_q && !failsafe_fail && new_q == cur_q |=> !swreq_q)
      else $error("redundant switch held");
   // Undivided setting ticks every enabled cycle
   a_div_one: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && div_q == 2'b00 ##1 div_q == 2'b00 |-> tick_q)
      else $error("undivided clock missed tick");
   // Brown-out drops the crystal enable and reloads both sources
   a_bor_load: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && brown_out_reset ##1 clk_en |=> !low_power_crystal_enable &&
      cur_q == $past(powerup_source_config) && new_q == $past(powerup_source_config))
      else $error("brown-out reload wrong");
   // Bits 4 and 2 never set; the first variant shows no trim either
   a_plain_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_rd[4] && !ctrl_rd[2] && (VARIANT == VAR_TRIM ||
      ctrl_rd[15:14] == 2'b00 && ctrl_rd[11:10] == 2'b00)) else $error("reserved bit set");
endmodule

// ==== logic/osc_ctrl_pkg.sv ====
// Constants, field layout and types for the oscillator control register block
package osc_ctrl_pkg;
   // APB word offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00; // Oscillator control word
   localparam logic [7:0] OFF_IRQ_STAT = 8'h04; // Sticky event status, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK = 8'h08; // Event enable mask

   // Bit positions inside the control word
   localparam int BIT_SWREQ = 0; // Clock switch request
   localparam int BIT_LPXEN = 1; // Low-power crystal enable
   localparam int BIT_FAIL = 3; // Clock failure flag
   localparam int BIT_LOCK = 5; // PLL lock flag
   localparam int POS_DIV = 6; // Divide select, two bits
   localparam int POS_NEW = 8; // Requested source, two bits
   localparam int POS_TRIM_LO = 10; // Trim bits 1:0
   localparam int POS_CUR = 12; // Current source, two bits
   localparam int POS_TRIM_HI = 14; // Trim bits 3:2

   // Unlock keys, index 0 is the low byte, index 1 the high byte
   localparam logic [1:0][7:0] KEY_FIRST = {8'h78, 8'h46};
   localparam logic [1:0][7:0] KEY_SECOND = {8'h9a, 8'h57};

   // Register variants
   localparam int VAR_PLAIN = 1; // No trim field
   localparam int VAR_TRIM = 2; // Split trim field in the control word

   // Event bits in status and mask
   localparam int IRQ_W = 3; // Number of events
   localparam int EVT_FAIL = 0; // Clock failure seen
   localparam int EVT_SWITCH = 1; // Clock switch finished
   localparam int EVT_LOCKLOST = 2; // PLL lost lock

   // Reset values
   localparam logic [1:0] DIV_RESET = 2'h0; // Undivided
   localparam logic [3:0] TRIM_RESET = 4'h0; // Factory calibrated
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0; // No events, all masked

   // Postscaler counter width, covers the largest ratio of 64
   localparam int DIV_CNT_W = 6;

   // Clock source encoding
   typedef enum logic [1:0] {
      SRC_LP_XTAL = 2'b00, // Low-power 32 kHz crystal
      SRC_FAST_RC = 2'b01, // Internal fast RC
      SRC_SLOW_RC = 2'b10, // Internal low-power RC
      SRC_PRIMARY = 2'b11 // Primary oscillator
   } src_t;

   // Unlock sequence states, Gray coded along the key path
   typedef enum logic [1:0] {
      UL_IDLE = 2'b00, // Waiting for first key
      UL_KEY = 2'b01, // First key seen
      UL_OPEN = 2'b11 // One write granted
   } unlock_t;
endpackage

// ==== tb/osc_ctrl_regs_tb.sv ====
// Self-checking bench for the oscillator control register block
`timescale 1ns/100ps
module osc_ctrl_regs_tb;
   import osc_ctrl_pkg::*;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00; // Bus address
   logic [31:0] pwdata = 32'h0; // Bus write data
   logic [3:0] pstrb = 4'h0; // Byte lanes
   logic [31:0] prdata; // Read data
   logic pready, pslverr, clock_switch_request, low_power_crystal_enable, sysclk_tick, irq;
   logic [1:0] powerup_source_config = 2'b10; // Power-up source, slow RC
   logic brown_out_reset = 0, switch_done = 0, failsafe_fail = 0;
   logic pll_locked = 0, pll_in_use = 0; // PLL lock detector and selection
   logic [1:0] current_clock_source, requested_clock_source;
   logic [3:0] fast_rc_trim; // Trim output
   logic [31:0] r; // Last read word
   logic e; // Last error response
   logic [3:0] t; // Trim under test
   int err_count = 0, checks = 0, cycles = 0, n;

   osc_ctrl_regs #(.VARIANT(VAR_TRIM)) osc_ctrl_regs_i (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .powerup_source_config(powerup_source_config), .brown_out_reset(brown_out_reset),
      .switch_done(switch_done), .failsafe_fail(failsafe_fail), .pll_locked(pll_locked),
      .pll_in_use(pll_in_use), .current_clock_source(current_clock_source),
      .requested_clock_source(requested_clock_source),
      .clock_switch_request(clock_switch_request),
      .low_power_crystal_enable(low_power_crystal_enable), .fast_rc_trim(fast_rc_trim),
      .sysclk_tick(sysclk_tick), .irq(irq));

   // Free-running 50 MHz clock
   always #10 pclk = ~pclk;

   // Hang guard, far above the expected run length
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         close_out();
      end
   end

   // Verdict and end of run
   task automatic close_out();
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Compare seen against expected, case equality so unknowns fail
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask

   // Expected control word, trim split across 15:14 and 11:10
   function automatic logic [31:0] ctl(input logic [1:0] cur, nw, dv, input logic [3:0] tr,
                                       input logic lk, fl, lx, rq);
      return {16'h0, tr[3:2], cur, tr[1:0], nw, dv, lk, 1'b0, fl, 1'b0, lx, rq};
   endfunction

   // Read a word and compare
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0, 4'h0);
      chk(nm, r, exp);
   endtask

   // Low byte keys then one granted lane-0 write
   task automatic unlock_lo(input logic [7:0] v);
      apb(1, OFF_CTRL, {24'h0, KEY_FIRST[0]}, 4'h1);
      apb(1, OFF_CTRL, {24'h0, KEY_SECOND[0]}, 4'h1);
      apb(1, OFF_CTRL, {24'h0, v}, 4'h1);
   endtask

   // High byte keys then one granted lane-1 write
   task automatic unlock_hi(input logic [7:0] v);
      apb(1, OFF_CTRL, {16'h0, KEY_FIRST[1], 8'h0}, 4'h2);
      apb(1, OFF_CTRL, {16'h0, KEY_SECOND[1], 8'h0}, 4'h2);
      apb(1, OFF_CTRL, {16'h0, v, 8'h0}, 4'h2);
   endtask

   // Pulse one event input for a cycle: 0 failure, 1 switch done, 2 brown-out
   task automatic pulse(input int which);
      if (which == 0) failsafe_fail <= 1;
      else if (which == 1) switch_done <= 1;
      else brown_out_reset <= 1;
      @(posedge pclk);
      failsafe_fail <= 0;
      switch_done <= 0;
      brown_out_reset <= 0;
      repeat (2) @(posedge pclk);
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      repeat (3) @(posedge pclk);
      rd("ctrl reset", OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 0));
      chk("cur src", current_clock_source, SRC_SLOW_RC);
      chk("new src", requested_clock_source, SRC_SLOW_RC);
      rd("mask reset", OFF_IRQ_MASK, 32'h0);
      // Plain write, then aborted and wrong-key sequences, all ignored
      apb(1, OFF_CTRL, 32'h0000ffff, 4'hf);
      rd("locked write", OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 0));
      apb(1, OFF_CTRL, 32'h46, 4'h1);
      rd("abort read", OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 0));
      apb(1, OFF_CTRL, 32'h57, 4'h1);
      apb(1, OFF_CTRL, 32'hc2, 4'h1);
      rd("aborted seq", OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 0));
      apb(1, OFF_CTRL, 32'h46, 4'h1);
      apb(1, OFF_CTRL, 32'h56, 4'h1);
      apb(1, OFF_CTRL, 32'hc2, 4'h1);
      rd("wrong key", OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 0));
      // Granted write takes, the next one does not
      unlock_lo(8'hc2);
      chk("crystal en", low_power_crystal_enable, 1'b1);
      apb(1, OFF_CTRL, 32'h0, 4'h1);
      rd("grant once", OFF_CTRL, ctl(2, 2, 3, 0, 0, 0, 1, 0));
      // Every divide ratio, ticks over a 128-cycle window after settling
      for (int i = 0; i < 4; i++) begin
         unlock_lo({i[1:0], 6'h02});
         repeat (70) @(posedge pclk);
         n = 0;
         repeat (128) begin
            @(posedge pclk);
            if (sysclk_tick === 1'b1) n++;
         end
         chk("tick count", n, 128 >> (2 * i));
      end
      unlock_lo(8'h02);
      // Trim codes; current source bits written as ones must not move
      for (int k = 0; k < 3; k++) begin
         t = (k == 0) ? 4'b0111 : (k == 1) ? 4'b0000 : 4'b1000;
         unlock_hi({t[3:2], 2'b11, t[1:0], 2'b11});
         chk("trim out", fast_rc_trim, t);
         rd("trim word", OFF_CTRL, ctl(2, 3, 0, t, 0, 0, 1, 0));
      end
      // Lock flag hidden unless the PLL clocks the system
      pll_locked <= 1;
      repeat (3) @(posedge pclk);
      rd("lock hidden", OFF_CTRL, ctl(2, 3, 0, 8, 0, 0, 1, 0));
      pll_in_use <= 1;
      repeat (3) @(posedge pclk);
      rd("lock shown", OFF_CTRL, ctl(2, 3, 0, 8, 1, 0, 1, 0));
      // Clock failure: flag, fall back to fast RC, interrupt
      apb(1, OFF_IRQ_MASK, 32'h7, 4'hf);
      pulse(0);
      chk("fail irq", irq, 1'b1);
      rd("fail stat", OFF_IRQ_STAT, 32'h1);
      rd("fail word", OFF_CTRL, ctl(1, 3, 0, 8, 1, 1, 1, 0));
      apb(1, OFF_IRQ_STAT, 32'h1, 4'hf);
      chk("irq cleared", irq, 1'b0);
      // Switch start clears failure; completion loads the new source
      pll_in_use <= 0;
      unlock_lo(8'h03);
      chk("req set", clock_switch_request, 1'b1);
      rd("switch start", OFF_CTRL, ctl(1, 3, 0, 8, 0, 0, 1, 1));
      pulse(1);
      chk("cur after", current_clock_source, SRC_PRIMARY);
      rd("switch end", OFF_CTRL, ctl(3, 3, 0, 8, 0, 0, 1, 0));
      rd("switch stat", OFF_IRQ_STAT, 32'h2);
      apb(1, OFF_IRQ_STAT, 32'h2, 4'hf);
      // Switch to the source already running is not left pending
      unlock_lo(8'h03);
      chk("redundant", clock_switch_request, 1'b0);
      // Loss of lock raises its event
      pll_in_use <= 1;
      pll_locked <= 0;
      repeat (3) @(posedge pclk);
      rd("lost stat", OFF_IRQ_STAT, 32'h4);
      // Software clears the failure flag in a granted write
      pulse(0);
      unlock_lo(8'h02);
      rd("sw clear", OFF_CTRL, ctl(1, 3, 0, 8, 0, 0, 1, 0));
      // A frozen block ignores a failure pulse
      clk_en <= 0;
      pulse(0);
      clk_en <= 1;
      rd("frozen", OFF_CTRL, ctl(1, 3, 0, 8, 0, 0, 1, 0));
      // Unmapped address answers with an error and zero data
      apb(0, 8'h0c, 32'h0, 4'h0);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", r, 32'h0);
      // Brown-out reloads sources and clears the writable fields
      powerup_source_config <= 2'b00;
      pulse(2);
      @(posedge pclk);
      rd("brown out", OFF_CTRL, ctl(0, 0, 0, 0, 0, 0, 0, 0));
      chk("crystal off", low_power_crystal_enable, 1'b0);
      close_out();
   end
endmodule
